/* src/netsetup_pkg.sv */
// constants for the network setup register block
`default_nettype none
package netsetup_pkg;
    localparam logic [2:0] SHARED_ADDR = 3'h7;
    localparam logic [1:0] SLOT_TENTATIVE = 2'h0;
    localparam logic [1:0] SLOT_NODE = 2'h1;
    localparam logic [1:0] SLOT_SETUP = 2'h2;
    localparam logic [1:0] SLOT_NEXT = 2'h3;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam int BIT_PULSE_STYLE = 7;
    localparam int BIT_SHORT_NACK = 6;
    localparam int BIT_TIMEOUT_THIRD = 5;
    localparam int BIT_ACCEPT_ALL = 4;
    localparam int BIT_RATE_HI = 3;
    localparam int BIT_RATE_LO = 1;
    localparam int BIT_HALVED_ARB = 0;
    localparam logic [7:0] NACK_LIMIT_SHORT = 8'h04;
    localparam logic [7:0] NACK_LIMIT_LONG = 8'h80;
    localparam int RATE_DIV_W = 9;
    localparam logic [2:0] RATE_CODE_MAX = 3'h5;
    localparam int CRYSTAL_HZ = 40000000;
    localparam int RAM_DEPTH = 1024;
    localparam int RAM_AW = 10;
    localparam int RAM_DW = 8;
endpackage
`default_nettype wire

/* src/network_setup_register.sv */
// network setup register and the settings it drives
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module network_setup_register (
    input wire logic core_clk,             // core clock, 40 MHz
    input wire logic rst_b,                // async reset, low
    input wire logic [2:0] regAddr,        // register address
    input wire logic regWr,                // register write strobe
    input wire logic regRd,                // register read strobe
    input wire logic [7:0] regWdata,       // write data
    input wire logic [1:0] shared_slot_selector, // sub-address from config
    output logic [7:0] regRdata,           // read data
    output logic [7:0] tentativeId,        // tentative identifier
    output logic [7:0] nodeId,             // own node identifier
    output logic [7:0] nextId,             // next identifier
    output logic pulse_one_drive_style,    // 1 push-pull, 0 open-drain
    output logic timeout_third_scale,      // timeouts divided by three
    output logic accept_every_packet,      // receive-all mode
    output logic halved_arbitration_select, // slow arbitration bit
    output logic [2:0] rate_divisor_select, // rate code
    input wire logic nackSeen,             // one refusal to buffer enquiry
    input wire logic nackClear,            // diagnostic flag clear
    output logic excess_refusal_flag,      // excess refusal flag
    input wire logic rxValid,              // valid packet received, pulse
    input wire logic [7:0] rxDest,         // its destination identifier
    output logic rxAccept,                 // packet kept, pulse
    output logic rxAck,                    // send acknowledgement, pulse
    output logic line_pulse_one,           // pulse-one line data
    output logic line_pulse_one_oe_b,      // pulse-one drive enable, low
    input wire logic txPulse,              // pulse request from protocol
    output logic bitTick,                  // bit-rate enable
    output logic halved_arbitration_clock, // arbitration enable
    input wire logic ramReq,               // buffer access request
    input wire logic ramWr,                // buffer write
    input wire logic [9:0] ramAddr,        // buffer location
    input wire logic [7:0] ramWdata,       // buffer write data
    output logic [7:0] ramRdata,           // buffer read data
    output logic ramDone                   // buffer cycle done, pulse
);
    logic [7:0] setup;
    logic [7:0] next_setup;
    logic [7:0] next_tentativeId;
    logic [7:0] next_nodeId;
    logic [7:0] next_nextId;
    logic [7:0] next_regRdata;
    logic [7:0] nackCount;
    logic [7:0] next_nackCount;
    logic [7:0] nackLimit;
    logic next_flag;
    logic next_rxAccept;
    logic next_rxAck;
    logic next_pulse;
    logic next_oe_b;
    logic sharedHit;
    logic [2:0] rateCode;
    logic bitEn;
    logic arbEn;
    logic setupWrite;
    logic next_driveStyle;
    logic next_thirdScale;
    logic next_acceptAll;
    logic next_halvedSelect;
    logic [2:0] next_rateSelect;
    logic next_bitTick;
    logic next_arbClock;

    ////////////////////////////////////////////////////////////////////////////
    // register access: address 7 is shared, the slot selector picks the register
    always_comb begin
        sharedHit = regAddr == netsetup_pkg::SHARED_ADDR;
        setupWrite = regWr && sharedHit && shared_slot_selector == netsetup_pkg::SLOT_SETUP;
        next_setup = setup;
        if (setupWrite) begin
            next_setup = regWdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            setup <= netsetup_pkg::SETUP_RESET;
        end else begin
            setup <= next_setup;
        end
    end

    // identifier registers behind the same address
    always_comb begin
        next_tentativeId = tentativeId;
        next_nodeId = nodeId;
        next_nextId = nextId;
        if (regWr && sharedHit) begin
            case (shared_slot_selector)
                netsetup_pkg::SLOT_TENTATIVE: next_tentativeId = regWdata;
                netsetup_pkg::SLOT_NODE: next_nodeId = regWdata;
                netsetup_pkg::SLOT_NEXT: next_nextId = regWdata;
                // the setup slot is taken by the block above
                default: next_nodeId = nodeId;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tentativeId <= 8'h00;
            nodeId <= 8'h00;
            nextId <= 8'h00;
        end else begin
            tentativeId <= next_tentativeId;
            nodeId <= next_nodeId;
            nextId <= next_nextId;
        end
    end

    // read path: data stands until the next read strobe
    always_comb begin
        next_regRdata = regRdata;
        if (regRd) begin
            next_regRdata = 8'h00;
            if (sharedHit) begin
                case (shared_slot_selector)
                    netsetup_pkg::SLOT_TENTATIVE: next_regRdata = tentativeId;
                    netsetup_pkg::SLOT_NODE: next_regRdata = nodeId;
                    netsetup_pkg::SLOT_SETUP: next_regRdata = setup;
                    netsetup_pkg::SLOT_NEXT: next_regRdata = nextId;
                    default: next_regRdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field outputs, taken from next_setup so they move on the write edge itself
    always_comb begin
        next_driveStyle = next_setup[netsetup_pkg::BIT_PULSE_STYLE];
        next_thirdScale = next_setup[netsetup_pkg::BIT_TIMEOUT_THIRD];
        next_acceptAll = next_setup[netsetup_pkg::BIT_ACCEPT_ALL];
        next_halvedSelect = next_setup[netsetup_pkg::BIT_HALVED_ARB];
        // reserved codes are kept as written so a read returns them unchanged
        next_rateSelect =
            next_setup[netsetup_pkg::BIT_RATE_HI:netsetup_pkg::BIT_RATE_LO];
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_one_drive_style <= 1'b0;
            timeout_third_scale <= 1'b0;
            accept_every_packet <= 1'b0;
            halved_arbitration_select <= 1'b0;
            rate_divisor_select <= 3'h0;
        end else begin
            pulse_one_drive_style <= next_driveStyle;
            timeout_third_scale <= next_thirdScale;
            accept_every_packet <= next_acceptAll;
            halved_arbitration_select <= next_halvedSelect;
            rate_divisor_select <= next_rateSelect;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // excess refusal counting
    // the limit follows the stored bit, so a change applies from the next refusal
    always_comb begin
        nackLimit = setup[netsetup_pkg::BIT_SHORT_NACK] ?
            netsetup_pkg::NACK_LIMIT_SHORT : netsetup_pkg::NACK_LIMIT_LONG;
        next_nackCount = nackCount;
        next_flag = excess_refusal_flag;
        if (nackClear) begin
            next_flag = 1'b0;
            next_nackCount = 8'h00;
        end
        // set beats clear: a refusal that reaches the limit in the clearing
        // cycle keeps the flag up, any other refusal there counts as the first
        if (nackSeen) begin
            if (nackCount + 8'h01 >= nackLimit) begin
                next_flag = 1'b1;
                next_nackCount = 8'h00;
            end else begin
                next_nackCount = next_nackCount + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            nackCount <= 8'h00;
            excess_refusal_flag <= 1'b0;
        end else begin
            nackCount <= next_nackCount;
            excess_refusal_flag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive filter and acknowledgement
    always_comb begin
        next_rxAccept = rxValid && (accept_every_packet || rxDest == nodeId);
        // acknowledge follows the node id alone, so a monitor never answers for others
        next_rxAck = rxValid && rxDest == nodeId;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxAccept <= 1'b0;
            rxAck <= 1'b0;
        end else begin
            rxAccept <= next_rxAccept;
            rxAck <= next_rxAck;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse-one driver: open-drain only ever pulls low
    always_comb begin
        if (pulse_one_drive_style) begin
            next_pulse = ~txPulse;
            next_oe_b = 1'b0;
        end else begin
            next_pulse = 1'b0;
            next_oe_b = ~txPulse;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_pulse_one <= 1'b0;
            line_pulse_one_oe_b <= 1'b1;
        end else begin
            line_pulse_one <= next_pulse;
            line_pulse_one_oe_b <= next_oe_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dividers and buffer
    // the divider re-reads the code only at a period boundary
    assign rateCode = rate_divisor_select;

    rate_divider u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .rateSel(rateCode),
        .halveArb(halved_arbitration_select),
        .bitEn(bitEn),
        .arbEn(arbEn)
    );

    // enables leave through a flop, so they trail the divider by one cycle
    always_comb begin
        next_bitTick = bitEn;
        next_arbClock = arbEn;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitTick <= 1'b0;
            halved_arbitration_clock <= 1'b0;
        end else begin
            bitTick <= next_bitTick;
            halved_arbitration_clock <= next_arbClock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packet buffer, paced by the same arbitration enable
    packet_ram u_ram (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .arbEn(arbEn),
        .req(ramReq),
        .wr(ramWr),
        .addr(ramAddr),
        .wdata(ramWdata),
        .rdata(ramRdata),
        .done(ramDone)
    );
endmodule
`default_nettype wire

/* src/packet_ram.sv */
// packet buffer, 1024 by 8, cycles paced by arbitration enable
`default_nettype none
module packet_ram (
    input wire logic core_clk,                       // core clock
    input wire logic rst_b,                          // async reset, low
    input wire logic arbEn,                          // arbitration slot
    input wire logic req,                            // access request, level
    input wire logic wr,                             // write when high
    input wire logic [netsetup_pkg::RAM_AW-1:0] addr, // location
    input wire logic [netsetup_pkg::RAM_DW-1:0] wdata, // write data
    output logic [netsetup_pkg::RAM_DW-1:0] rdata,   // read data
    output logic done                                // one-cycle completion
);
    logic [netsetup_pkg::RAM_DW-1:0] mem [netsetup_pkg::RAM_DEPTH];
    logic [netsetup_pkg::RAM_DW-1:0] next_rdata;
    logic next_done;
    logic take;

    // a cycle only completes in an arbitration slot
    always_comb begin
        take = req && arbEn && !done;
        next_done = take;
        next_rdata = rdata;
        if (take && !wr) begin
            next_rdata = mem[addr];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
            done <= 1'b0;
        end else begin
            rdata <= next_rdata;
            done <= next_done;
        end
    end

    // storage carries no reset, as a real array would not
    always_ff @(posedge core_clk) begin
        if (take && wr) begin
            mem[addr] <= wdata;
        end
    end
endmodule
`default_nettype wire

/* src/rate_divider.sv */
// glitch-free enable divider for bit rate and arbitration
`default_nettype none
module rate_divider (
    input wire logic core_clk,          // core clock
    input wire logic rst_b,             // async reset, low
    input wire logic [2:0] rateSel,     // divisor code
    input wire logic halveArb,          // halve arbitration enable
    output logic bitEn,                 // one-cycle bit-rate pulse
    output logic arbEn                  // arbitration enable, high every cycle, or a one-cycle pulse every other cycle when halved
);
    logic [netsetup_pkg::RATE_DIV_W-1:0] count;
    logic [netsetup_pkg::RATE_DIV_W-1:0] next_count;
    logic [netsetup_pkg::RATE_DIV_W-1:0] limit;
    logic [2:0] code;
    logic [2:0] next_code;
    logic arbPhase;
    logic next_arbPhase;
    logic next_bitEn;
    logic next_arbEn;

    // new code only latched at a period boundary, so no runt period
    always_comb begin
        limit = netsetup_pkg::RATE_DIV_W'(9'h008 << code) - 9'h001;
        next_count = count + 9'h001;
        next_code = code;
        next_bitEn = 1'b0;
        if (count >= limit) begin
            next_count = '0;
            next_bitEn = 1'b1;
            // reserved codes fall back to the slowest legal divisor
            next_code = (rateSel > netsetup_pkg::RATE_CODE_MAX) ?
                netsetup_pkg::RATE_CODE_MAX : rateSel;
        end
        next_arbPhase = halveArb ? ~arbPhase : 1'b1;
        next_arbEn = halveArb ? arbPhase : 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            code <= 3'h0;
            bitEn <= 1'b0;
            arbPhase <= 1'b0;
            arbEn <= 1'b0;
        end else begin
            count <= next_count;
            code <= next_code;
            bitEn <= next_bitEn;
            arbPhase <= next_arbPhase;
            arbEn <= next_arbEn;
        end
    end
endmodule
`default_nettype wire

/* tb/network_setup_register_checker.sv */
// concurrent checks on the setup register ports
`default_nettype none
module network_setup_register_checker (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic [2:0] regAddr, // in
    input wire logic regWr, // in
    input wire logic regRd, // in
    input wire logic [7:0] regWdata, // in
    input wire logic [1:0] shared_slot_selector, // in
    input wire logic [7:0] regRdata, // out
    input wire logic [7:0] nodeId, // out
    input wire logic pulse_one_drive_style, // out
    input wire logic timeout_third_scale, // out
    input wire logic accept_every_packet, // out
    input wire logic halved_arbitration_select, // out
    input wire logic [2:0] rate_divisor_select, // out
    input wire logic nackClear, // in
    input wire logic excess_refusal_flag, // out
    input wire logic rxValid, // in
    input wire logic [7:0] rxDest, // in
    input wire logic rxAccept, // out
    input wire logic rxAck, // out
    input wire logic line_pulse_one, // out
    input wire logic line_pulse_one_oe_b, // out
    input wire logic txPulse, // in
    input wire logic bitTick, // out
    input wire logic halved_arbitration_clock // out
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
wire logic slotSetup = regAddr == netsetup_pkg::SHARED_ADDR
    && shared_slot_selector == netsetup_pkg::SLOT_SETUP;
wire logic [6:0] fields = {pulse_one_drive_style, timeout_third_scale, accept_every_packet,
    rate_divisor_select, halved_arbitration_select};
sequence setupWr;
    regWr && slotSetup;
endsequence
sequence rxMatch;
    rxValid && rxDest == nodeId;
endsequence
////////////////////////////////////////////////////////////////////////////////
a_write_fields: assert property (setupWr
    |=> fields == $past({regWdata[7], regWdata[5:0]}))
    else $error("setup fields differ from write");
a_fields_hold: assert property (!(regWr && slotSetup) |=> $stable(fields))
    else $error("setup fields moved without a write");
a_read_back: assert property (regRd && slotSetup
    |=> {regRdata[7], regRdata[5:0]} == $past(fields))
    else $error("setup read differs from fields");
a_ack_match: assert property (rxMatch |=> rxAck && rxAccept)
    else $error("matching packet not acknowledged");
a_ack_only: assert property (rxAck |-> $past(rxValid && rxDest == nodeId))
    else $error("acknowledge without matching packet");
a_accept_all: assert property (rxValid && accept_every_packet |=> rxAccept)
    else $error("receive-all packet dropped");
a_push_pull: assert property ($past(pulse_one_drive_style)
    |-> !line_pulse_one_oe_b && line_pulse_one == !$past(txPulse))
    else $error("push-pull drive wrong");
a_open_drain: assert property (!$past(pulse_one_drive_style)
    |-> !line_pulse_one && line_pulse_one_oe_b == !$past(txPulse))
    else $error("open-drain drive wrong");
a_flag_sticky: assert property (excess_refusal_flag && !nackClear |=> excess_refusal_flag)
    else $error("refusal flag dropped without clear");
a_tick_spacing: assert property (bitTick |=> !bitTick [*7])
    else $error("bit tick closer than eight cycles");
a_arb_full: assert property (!halved_arbitration_select [*3] |-> halved_arbitration_clock)
    else $error("arbitration enable missing");
a_arb_half: assert property (halved_arbitration_select [*4]
    |-> halved_arbitration_clock != $past(halved_arbitration_clock))
    else $error("arbitration enable not halved");
endmodule
bind network_setup_register network_setup_register_checker chk_u (.core_clk, .rst_b, .regAddr,
    .regWr, .regRd, .regWdata, .shared_slot_selector, .regRdata, .nodeId, .pulse_one_drive_style,
    .timeout_third_scale, .accept_every_packet, .halved_arbitration_select, .rate_divisor_select,
    .nackClear, .excess_refusal_flag, .rxValid, .rxDest, .rxAccept, .rxAck, .line_pulse_one,
    .line_pulse_one_oe_b, .txPulse, .bitTick, .halved_arbitration_clock);
`default_nettype wire

/* tb/network_setup_register_tb.sv */
// self-checking bench for the setup register
`default_nettype none
module network_setup_register_tb;
timeunit 1ns;
timeprecision 100ps;
logic core_clk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0, nackSeen = 1'h0;
logic nackClear = 1'h0, rxValid = 1'h0, txPulse = 1'h0, ramReq = 1'h0, ramWr = 1'h0;
logic [2:0] regAddr = 3'h0;
logic [1:0] shared_slot_selector = 2'h0;
logic [7:0] regWdata = 8'h00, rxDest = 8'h00, ramWdata = 8'h00;
logic [9:0] ramAddr = 10'h000;
logic [7:0] regRdata, tentativeId, nodeId, nextId, ramRdata;
logic [2:0] rate_divisor_select;
logic pulse_one_drive_style, timeout_third_scale, accept_every_packet, halved_arbitration_select;
logic excess_refusal_flag, rxAccept, rxAck, line_pulse_one, line_pulse_one_oe_b, bitTick;
logic halved_arbitration_clock, ramDone;
int n_errors = 0, checked = 0;
network_setup_register dut_u (.core_clk, .rst_b, .regAddr, .regWr, .regRd, .regWdata,
    .shared_slot_selector, .regRdata, .tentativeId, .nodeId, .nextId, .pulse_one_drive_style,
    .timeout_third_scale, .accept_every_packet, .halved_arbitration_select, .rate_divisor_select,
    .nackSeen, .nackClear, .excess_refusal_flag, .rxValid, .rxDest, .rxAccept, .rxAck,
    .line_pulse_one, .line_pulse_one_oe_b, .txPulse, .bitTick, .halved_arbitration_clock,
    .ramReq, .ramWr, .ramAddr, .ramWdata, .ramRdata, .ramDone);
always #12.5 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task automatic tick;
    @(posedge core_clk);
    #2;
endtask
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic chkInt(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
        n_errors++;
        $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
endtask
// each access leaves one idle edge so strobes never re-rise in the same step
task automatic wrReg(input logic [2:0] a, input logic [1:0] s, input logic [7:0] d);
    regAddr = a;
    shared_slot_selector = s;
    regWdata = d;
    regWr = 1'h1;
    tick;
    regWr = 1'h0;
    tick;
endtask
task automatic rdReg(input logic [2:0] a, input logic [1:0] s, output logic [7:0] d);
    regAddr = a;
    shared_slot_selector = s;
    regRd = 1'h1;
    tick;
    regRd = 1'h0;
    d = regRdata;
    tick;
endtask
task automatic waitTick(output int n);
    n = 0;
    do begin
        tick;
        n++;
    end while (bitTick !== 1'h1 && n < 600);
    if (n >= 600) begin
        n_errors++;
        give_verdict;
    end
endtask
task automatic nacks(input int k);
    nackSeen = 1'h1;
    repeat (k) tick;
    nackSeen = 1'h0;
endtask
task automatic clearFlag;
    nackClear = 1'h1;
    tick;
    nackClear = 1'h0;
    tick;
endtask
task automatic rxPkt(input logic [7:0] d, input logic [1:0] e);
    rxValid = 1'h1;
    rxDest = d;
    tick;
    rxValid = 1'h0;
    chk("accept/ack", {6'h00, e}, {6'h00, rxAccept, rxAck});
    tick;
    chk("accept/ack end", 8'h00, {6'h00, rxAccept, rxAck});
endtask
task automatic ramOp(input logic w, input logic [7:0] d, output int n, output logic [7:0] q);
    ramReq = 1'h1;
    ramWr = w;
    ramAddr = 10'h3ff;
    ramWdata = d;
    n = 0;
    do begin
        tick;
        n++;
    end while (ramDone !== 1'h1 && n < 50);
    if (n >= 50) begin
        n_errors++;
        give_verdict;
    end
    ramReq = 1'h0;
    q = ramRdata;
    tick;
endtask
task automatic arbCount(input int e);
    int n;
    n = 0;
    repeat (8) begin
        tick;
        n += int'(halved_arbitration_clock === 1'h1);
    end
    chkInt("arb enables", e, n);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic testReset;
    logic [7:0] d;
    rdReg(3'h7, netsetup_pkg::SLOT_SETUP, d);
    chk("setup reset", netsetup_pkg::SETUP_RESET, d);
    chk("outputs reset", 8'h01, {pulse_one_drive_style, timeout_third_scale,
        accept_every_packet, rate_divisor_select, halved_arbitration_select,
        line_pulse_one_oe_b});
    chk("flag reset", 8'h00, {7'h00, excess_refusal_flag});
endtask
task automatic testRegs;
    logic [7:0] d;
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'hbe);
    chk("fields", 8'h7e, {1'h0, pulse_one_drive_style, timeout_third_scale, accept_every_packet,
        rate_divisor_select, halved_arbitration_select});
    wrReg(3'h7, netsetup_pkg::SLOT_TENTATIVE, 8'h55);
    wrReg(3'h7, netsetup_pkg::SLOT_NEXT, 8'h3c);
    wrReg(3'h3, netsetup_pkg::SLOT_SETUP, 8'h00);
    rdReg(3'h7, netsetup_pkg::SLOT_SETUP, d);
    chk("setup read", 8'hbe, d);
    rdReg(3'h7, netsetup_pkg::SLOT_TENTATIVE, d);
    chk("tentative read", 8'h55, d);
    chk("tentative id", 8'h55, tentativeId);
    chk("next id", 8'h3c, nextId);
    rdReg(3'h3, netsetup_pkg::SLOT_SETUP, d);
    chk("unmapped read", 8'h00, d);
endtask
task automatic testRate;
    int n;
    for (int i = 0; i < 8; i++) begin
        wrReg(3'h7, netsetup_pkg::SLOT_SETUP, {4'h0, 3'(i), 1'h0});
        chk("rate code", 8'(i), {5'h00, rate_divisor_select});
        waitTick(n);
        waitTick(n);
        waitTick(n);
        chkInt("rate period", (i > 5) ? 256 : (8 << i), n);
    end
endtask
task automatic testNack;
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'h40);
    nacks(3);
    tick;
    chk("flag after 3", 8'h00, {7'h00, excess_refusal_flag});
    nacks(1);
    chk("flag after 4", 8'h01, {7'h00, excess_refusal_flag});
    clearFlag;
    nacks(3);
    tick;
    nackClear = 1'h1;
    nacks(1);
    nackClear = 1'h0;
    chk("set beats clear", 8'h01, {7'h00, excess_refusal_flag});
    clearFlag;
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'h00);
    nacks(127);
    tick;
    chk("flag after 127", 8'h00, {7'h00, excess_refusal_flag});
    nacks(1);
    chk("flag after 128", 8'h01, {7'h00, excess_refusal_flag});
    clearFlag;
    chk("flag cleared", 8'h00, {7'h00, excess_refusal_flag});
endtask
task automatic testRx;
    wrReg(3'h7, netsetup_pkg::SLOT_NODE, 8'h2a);
    chk("node id", 8'h2a, nodeId);
    rxPkt(8'h2a, 2'h3);
    rxPkt(8'h13, 2'h0);
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'h10);
    rxPkt(8'h13, 2'h2);
    rxPkt(8'h2a, 2'h3);
endtask
task automatic testDrive;
    for (int s = 0; s < 2; s++) begin
        wrReg(3'h7, netsetup_pkg::SLOT_SETUP, {s[0], 7'h00});
        txPulse = 1'h1;
        tick;
        chk("pulse on", 8'h00, {6'h00, line_pulse_one, line_pulse_one_oe_b});
        txPulse = 1'h0;
        tick;
        chk("pulse off", s ? 8'h02 : 8'h01, {6'h00, line_pulse_one, line_pulse_one_oe_b});
    end
endtask
task automatic testRam;
    int n, ln, lh;
    logic [7:0] q;
    ln = 0;
    lh = 0;
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'h00);
    arbCount(8);
    ramOp(1'h1, 8'ha5, n, q);
    for (int i = 0; i < 2; i++) begin
        repeat (i) tick;
        ramOp(1'h0, 8'h00, n, q);
        ln += n;
        chk("ram read", 8'ha5, q);
    end
    chkInt("normal latency", 2, ln);
    wrReg(3'h7, netsetup_pkg::SLOT_SETUP, 8'h01);
    arbCount(4);
    for (int i = 0; i < 2; i++) begin
        repeat (i) tick;
        ramOp(1'h0, 8'h00, n, q);
        lh += n;
        chk("ram read slow", 8'ha5, q);
    end
    chkInt("slow is longer", 1, int'(lh > ln));
endtask
initial begin
    repeat (4) @(posedge core_clk);
    #2;
    rst_b = 1'h1;
    testReset;
    testRegs;
    testRate;
    testNack;
    testRx;
    testDrive;
    testRam;
    give_verdict;
end
endmodule
`default_nettype wire
